//--- logic/rnc_pkg.sv
// Overview of operation
// (RULE1) Clear-channel select forms the clear-channel flag
// (RULE2) After-receive field picks state after reception
// (RULE3) Host never pairs transmit-after-receive with clear-channel
// (RULE4) After-transmit field picks state after transmission
// (RULE5) Autocal zero: calibrate only on calibrate strobe
// (RULE6) Autocal one: calibrate when leaving idle
// (RULE7) Autocal two: calibrate on automatic return idle
// (RULE8) Autocal three: calibrate every fourth automatic return
// (RULE9) Host may prefer every-fourth setting for wake-listen
// (RULE10) Top two reserved bits read zero, ignore writes
`default_nettype none
package rnc_pkg;
   // Register addresses
   localparam logic [7:0] RNC_NEXT_STATE_ADDR = 8'h17;
   localparam logic [7:0] RNC_AUTOCAL_ADDR = 8'h18;

   // Field positions
   localparam int RNC_CLEAR_SEL_LSB = 4;
   localparam int RNC_RXOFF_LSB = 2;
   localparam int RNC_TXOFF_LSB = 0;
   localparam int RNC_AUTOCAL_LSB = 4;

   // Writable bits of each register
   localparam logic [7:0] RNC_NEXT_STATE_MASK = 8'h3F;
   localparam logic [7:0] RNC_AUTOCAL_MASK = 8'h30;

   // Values after reset
   localparam logic [7:0] RNC_NEXT_STATE_RESET = 8'h30;
   localparam logic [7:0] RNC_AUTOCAL_RESET = 8'h00;
   localparam logic [7:0] RNC_UNMAPPED_READ = 8'h00;

   // Clear-channel select codes
   localparam logic [1:0] RNC_CLEAR_ALWAYS = 2'h0;
   localparam logic [1:0] RNC_CLEAR_RSSI = 2'h1;
   localparam logic [1:0] RNC_CLEAR_NOT_RX = 2'h2;
   localparam logic [1:0] RNC_CLEAR_RSSI_NOT_RX = 2'h3;

   // Autocal select codes
   localparam logic [1:0] RNC_CAL_NEVER = 2'h0;
   localparam logic [1:0] RNC_CAL_IDLE_EXIT = 2'h1;
   localparam logic [1:0] RNC_CAL_RETURN = 2'h2;
   localparam logic [1:0] RNC_CAL_EVERY4 = 2'h3;

   // Return counter: calibrate when the count stands at its last value
   localparam logic [1:0] RNC_RETURN_COUNT_RESET = 2'h0;
   localparam logic [1:0] RNC_RETURN_COUNT_LAST = 2'h3;

   // Next-state field codes, shared by both after-packet fields
   localparam logic [1:0] RNC_NS_IDLE = 2'h0;
   localparam logic [1:0] RNC_NS_SYNTH_ON = 2'h1;
   localparam logic [1:0] RNC_NS_TX = 2'h2;
   localparam logic [1:0] RNC_NS_RX = 2'h3;

   typedef enum logic [1:0] {
      RNC_IDLE,
      RNC_SYNTH_ON_TX_READY,
      RNC_TX,
      RNC_RX
   } rnc_state_t;
endpackage
`default_nettype wire

//--- logic/rnc_autocal.sv
`default_nettype none
module rnc_autocal (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Configuration
   input wire logic [1:0] synth_autocal_select,
   // Events from the radio state machine
   input wire logic calibrate_strobe,
   input wire logic idle_exit,
   input wire logic auto_return_idle,
   // Results
   output logic cal_start,
   output logic [1:0] return_count
);
   logic cal_d;
   logic cal_q;
   logic [1:0] cnt_d;
   logic [1:0] cnt_q;

   always_comb begin
      cnt_d = cnt_q;
      cal_d = 1'b0;
      if (calibrate_strobe) begin
         cal_d = 1'b1; // RULE5
      end
      unique case (synth_autocal_select)
         rnc_pkg::RNC_CAL_NEVER: begin
            cnt_d = cnt_q; // RULE5
         end
         rnc_pkg::RNC_CAL_IDLE_EXIT: begin
            if (idle_exit) begin
               cal_d = 1'b1; // RULE6
            end
         end
         rnc_pkg::RNC_CAL_RETURN: begin
            if (auto_return_idle) begin
               cal_d = 1'b1; // RULE7
            end
         end
         rnc_pkg::RNC_CAL_EVERY4: begin
            // Counting only in this mode keeps other modes from skewing it
            if (auto_return_idle) begin
               cnt_d = cnt_q + 2'h1; // RULE8
               if (cnt_q == rnc_pkg::RNC_RETURN_COUNT_LAST) begin
                  cal_d = 1'b1; // RULE8
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cal_q <= 1'b0;
         cnt_q <= rnc_pkg::RNC_RETURN_COUNT_RESET;
      end else begin
         cal_q <= cal_d;
         cnt_q <= cnt_d;
      end
   end

   assign cal_start = cal_q;
   assign return_count = cnt_q;
endmodule
`default_nettype wire

//--- logic/rnc_config.sv
`default_nettype none
module rnc_config (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rdata,
   // Channel status from the receiver
   input wire logic rssi_below_thresh,
   input wire logic receiving_packet,
   output logic clear_channel_flag,
   // Packet completion events
   input wire logic rx_done,
   input wire logic tx_done,
   output var rnc_pkg::rnc_state_t next_state,
   output logic next_state_valid,
   // Calibration
   input wire logic calibrate_strobe,
   input wire logic idle_exit,
   input wire logic auto_return_idle,
   output logic cal_start,
   // Field views for the state machine
   output logic [1:0] after_receive_next_state,
   output logic [1:0] after_transmit_next_state,
   output logic [1:0] synth_autocal_select
);
   // Configuration registers
   logic [7:0] ns_cfg_d;
   logic [7:0] ns_cfg_q;
   logic [7:0] cal_cfg_d;
   logic [7:0] cal_cfg_q;

   // Read-back
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;

   // Clear-channel flag
   logic clear_d;
   logic clear_q;

   // Next-state report
   rnc_pkg::rnc_state_t ns_d;
   rnc_pkg::rnc_state_t ns_q;
   logic ns_valid_d;
   logic ns_valid_q;

   // Field slices and address decode
   logic [1:0] clear_sel;
   logic [1:0] rxoff_sel;
   logic [1:0] txoff_sel;
   logic [1:0] autocal_sel;
   logic [1:0] addr_hit;

   // Both after-packet fields share one code-to-state map
   function automatic rnc_pkg::rnc_state_t field_to_state(input logic [1:0] code);
      rnc_pkg::rnc_state_t s;
      s = rnc_pkg::RNC_IDLE;
      unique case (code)
         rnc_pkg::RNC_NS_IDLE: s = rnc_pkg::RNC_IDLE;
         rnc_pkg::RNC_NS_SYNTH_ON: s = rnc_pkg::RNC_SYNTH_ON_TX_READY;
         rnc_pkg::RNC_NS_TX: s = rnc_pkg::RNC_TX;
         rnc_pkg::RNC_NS_RX: s = rnc_pkg::RNC_RX;
      endcase
      return s;
   endfunction

   // Write and read paths share one decode: bit 0 next-state, bit 1 autocal
   function automatic logic [1:0] decode_addr(input logic [7:0] addr);
      logic [1:0] hit;
      hit = 2'h0;
      if (addr == rnc_pkg::RNC_NEXT_STATE_ADDR) begin
         hit[0] = 1'b1;
      end
      if (addr == rnc_pkg::RNC_AUTOCAL_ADDR) begin
         hit[1] = 1'b1;
      end
      return hit;
   endfunction

   // Field slices of the two configuration registers
   assign clear_sel = ns_cfg_q[rnc_pkg::RNC_CLEAR_SEL_LSB +: 2];
   assign rxoff_sel = ns_cfg_q[rnc_pkg::RNC_RXOFF_LSB +: 2];
   assign txoff_sel = ns_cfg_q[rnc_pkg::RNC_TXOFF_LSB +: 2];
   assign autocal_sel = cal_cfg_q[rnc_pkg::RNC_AUTOCAL_LSB +: 2];
   assign addr_hit = decode_addr(reg_addr);

   // Next-state configuration register
   always_comb begin
      ns_cfg_d = ns_cfg_q;
      if (reg_wr_en && addr_hit[0]) begin
         ns_cfg_d = reg_wdata & rnc_pkg::RNC_NEXT_STATE_MASK; // RULE10
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ns_cfg_q <= rnc_pkg::RNC_NEXT_STATE_RESET;
      end else begin
         ns_cfg_q <= ns_cfg_d;
      end
   end

   // Autocal configuration register; only the select field is kept
   always_comb begin
      cal_cfg_d = cal_cfg_q;
      if (reg_wr_en && addr_hit[1]) begin
         cal_cfg_d = reg_wdata & rnc_pkg::RNC_AUTOCAL_MASK; // RULE10
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cal_cfg_q <= rnc_pkg::RNC_AUTOCAL_RESET;
      end else begin
         cal_cfg_q <= cal_cfg_d;
      end
   end

   // Read data holds until the next read, so the host may sample late;
   // a read beside a write to the same register returns the old value
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd_en) begin
         if (addr_hit[0]) begin
            rdata_d = ns_cfg_q;
         end else if (addr_hit[1]) begin
            rdata_d = cal_cfg_q;
         end else begin
            rdata_d = rnc_pkg::RNC_UNMAPPED_READ;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rdata_q <= rnc_pkg::RNC_UNMAPPED_READ;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Clear-channel indication
   always_comb begin
      clear_d = 1'b1;
      unique case (clear_sel)
         rnc_pkg::RNC_CLEAR_ALWAYS: clear_d = 1'b1; // RULE1
         rnc_pkg::RNC_CLEAR_RSSI: clear_d = rssi_below_thresh; // RULE1
         rnc_pkg::RNC_CLEAR_NOT_RX: clear_d = !receiving_packet; // RULE1
         rnc_pkg::RNC_CLEAR_RSSI_NOT_RX: begin
            clear_d = rssi_below_thresh && !receiving_packet; // RULE1
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         clear_q <= 1'b0;
      end else begin
         clear_q <= clear_d;
      end
   end

   // Next state after a packet; the radio never finishes both at once,
   // reception is given priority in case a caller misbehaves
   always_comb begin
      ns_d = ns_q;
      if (rx_done) begin
         ns_d = field_to_state(rxoff_sel); // RULE2
      end else if (tx_done) begin
         ns_d = field_to_state(txoff_sel); // RULE4
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ns_q <= rnc_pkg::RNC_IDLE;
      end else begin
         ns_q <= ns_d;
      end
   end

   // Valid marks the one cycle in which a fresh next state stands
   always_comb begin
      ns_valid_d = 1'b0;
      if (rx_done || tx_done) begin
         ns_valid_d = 1'b1; // RULE2 RULE4
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ns_valid_q <= 1'b0;
      end else begin
         ns_valid_q <= ns_valid_d;
      end
   end

   // Return counter stays internal: the host never reads it
   rnc_autocal u_autocal (
      .mclk(mclk),
      .resetn(resetn),
      .synth_autocal_select(autocal_sel),
      .calibrate_strobe(calibrate_strobe),
      .idle_exit(idle_exit),
      .auto_return_idle(auto_return_idle),
      .cal_start(cal_start),
      .return_count()
   );

   assign reg_rdata = rdata_q;
   assign clear_channel_flag = clear_q;
   assign next_state = ns_q;
   assign next_state_valid = ns_valid_q;
   // Field views are register bits, so they come straight from flops
   assign after_receive_next_state = rxoff_sel;
   assign after_transmit_next_state = txoff_sel;
   assign synth_autocal_select = autocal_sel;
endmodule
`default_nettype wire

//--- testbench/rnc_config_properties.sv
`default_nettype none
module rnc_config_props (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_rdata,
   // Channel and packet events
   input wire logic rssi_below_thresh,
   input wire logic receiving_packet,
   input wire logic clear_channel_flag,
   input wire logic rx_done,
   input wire logic tx_done,
   input wire rnc_pkg::rnc_state_t next_state,
   input wire logic next_state_valid,
   // Calibration and fields
   input wire logic calibrate_strobe,
   input wire logic idle_exit,
   input wire logic auto_return_idle,
   input wire logic cal_start,
   input wire logic [1:0] after_receive_next_state,
   input wire logic [1:0] after_transmit_next_state,
   input wire logic [1:0] synth_autocal_select
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] mode_d, mode_q, cnt_d, cnt_q;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   function automatic logic clr(input logic [1:0] m, input logic r, input logic p);
      return (!m[0] || r) && (!m[1] || !p);
   endfunction
   always_comb begin
      mode_d = mode_q;
      cnt_d = cnt_q;
      if (reg_wr_en && reg_addr == 8'h17) mode_d = reg_wdata[5:4];
      if (synth_autocal_select == 2'h3 && auto_return_idle) cnt_d = cnt_q + 2'h1;
   end
   always_ff @(posedge mclk) begin
      mode_q <= resetn ? mode_d : 2'h3;
      cnt_q <= resetn ? cnt_d : 2'h0;
   end
   a_flag_by_mode: assert property ($past(resetn) |-> clear_channel_flag ==
      clr($past(mode_q), $past(rssi_below_thresh), $past(receiving_packet))) else $error("flag");
   a_valid_one_pulse: assert property ($past(resetn) |->
      next_state_valid == $past(rx_done || tx_done)) else $error("valid");
   a_next_after_rx: assert property (rx_done |=>
      next_state == $past(after_receive_next_state)) else $error("rx next");
   a_next_after_tx: assert property (tx_done && !rx_done |=>
      next_state == $past(after_transmit_next_state)) else $error("tx next");
   a_cal_never: assert property (synth_autocal_select == 2'h0 && !calibrate_strobe
      |=> !cal_start) else $error("cal never");
   a_cal_strobe: assert property (calibrate_strobe |=> cal_start) else $error("strobe");
   a_cal_idle_exit: assert property (synth_autocal_select == 2'h1 && !calibrate_strobe
      |=> cal_start == $past(idle_exit)) else $error("cal exit");
   a_cal_each_return: assert property (synth_autocal_select == 2'h2 && !calibrate_strobe
      |=> cal_start == $past(auto_return_idle)) else $error("cal return");
   a_cal_fourth_return: assert property (synth_autocal_select == 2'h3 && !calibrate_strobe
      |=> cal_start == $past(auto_return_idle && cnt_q == 2'h3)) else $error("cal 4th");
   a_reserved_zero: assert property (reg_rd_en |=> reg_rdata[7:6] == 2'h0) else $error("rsvd");
   c_rx_done: cover property (rx_done);
   c_fourth: cover property (synth_autocal_select == 2'h3 && auto_return_idle && cnt_q == 2'h3);
   c_cal_write: cover property (reg_wr_en && reg_addr == 8'h18);
endmodule
`default_nettype wire

//--- testbench/rnc_host.sv
`default_nettype none
module rnc_host (
   // Register port
   input wire logic mclk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr_en,
   output logic reg_rd_en,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {reg_addr, reg_wdata, reg_wr_en, reg_rd_en} = 18'h00000;
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(negedge mclk);
      reg_addr = a;
      // Transmit-type after-receive drops clear-channel use
      reg_wdata = (a == 8'h17 && ^w[3:2]) ? (w & 8'hCF) : w;
      reg_wr_en = 1'b1;
      @(negedge mclk);
      reg_wr_en = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      @(negedge mclk);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge mclk);
      reg_rd_en = 1'b0;
      r = reg_rdata;
   endtask
endmodule
`default_nettype wire

//--- testbench/test_rnc_config.sv
`default_nettype none
module test_rnc_config;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0, resetn, rssi_below_thresh, receiving_packet, rx_done, tx_done;
   logic calibrate_strobe, idle_exit, auto_return_idle, reg_wr_en, reg_rd_en;
   logic clear_channel_flag, next_state_valid, cal_start, ef, ec;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [1:0] after_receive_next_state, after_transmit_next_state, synth_autocal_select;
   rnc_pkg::rnc_state_t next_state;
   int failures = 0, n_checks = 0, cyc = 0, cnt = 0, seed = 42842;
   rnc_config u_rnc_config (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr_en, .reg_rd_en,
      .reg_rdata, .rssi_below_thresh, .receiving_packet, .clear_channel_flag, .rx_done,
      .tx_done, .next_state, .next_state_valid, .calibrate_strobe, .idle_exit,
      .auto_return_idle, .cal_start, .after_receive_next_state, .after_transmit_next_state,
      .synth_autocal_select);
   rnc_host u_rnc_host (.mclk, .reg_addr, .reg_wdata, .reg_wr_en, .reg_rd_en, .reg_rdata);
   always #25 mclk = ~mclk;
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      u_rnc_host.rd(a, d);
      chk(d, e);
   endtask
   task automatic conclude();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      resetn = 1'b0;
      {rssi_below_thresh, receiving_packet, rx_done, tx_done} = 4'h0;
      {calibrate_strobe, idle_exit, auto_return_idle} = 3'h0;
      repeat (16) @(negedge mclk);
      resetn = 1'b1;
      rchk(8'h17, 8'h30);
      rchk(8'h18, 8'h00);
      rchk(8'h3C, 8'h00);
      u_rnc_host.wr(8'h17, 8'hFF);
      rchk(8'h17, 8'h3F);
      u_rnc_host.wr(8'h18, 8'hFF);
      rchk(8'h18, 8'h30);
      for (int c = 0; c < 4; c++) begin
         u_rnc_host.wr(8'h17, 8'(c * 3 + 3));
         chk(after_receive_next_state, 8'(c));
         chk(after_transmit_next_state, 8'(3 - c));
         rx_done = 1'b1;
         @(negedge mclk);
         chk(next_state, 8'(c));
         chk(next_state_valid, 8'h01);
         rx_done = 1'b0;
         tx_done = 1'b1;
         @(negedge mclk);
         chk(next_state, 8'(3 - c));
         tx_done = 1'b0;
         @(negedge mclk);
         chk(next_state_valid, 8'h00);
      end
      // Mode 3 last: the low-current wake-listen choice
      for (int m = 0; m < 4; m++) begin
         u_rnc_host.wr(8'h17, 8'(m * 16));
         u_rnc_host.wr(8'h18, 8'(m * 16));
         chk(synth_autocal_select, 8'(m));
         for (int i = 0; i < 24; i++) begin
            @(negedge mclk);
            if (i > 0) chk(clear_channel_flag, ef);
            if (i > 0) chk(cal_start, ec);
            {rssi_below_thresh, receiving_packet, idle_exit, auto_return_idle} = 4'($random(seed));
            calibrate_strobe = ($random(seed) & 7) == 0;
            ef = m == 0 || (m == 1 && rssi_below_thresh) || (m == 2 && !receiving_packet)
               || (m == 3 && rssi_below_thresh && !receiving_packet);
            ec = calibrate_strobe || (m == 1 && idle_exit) || (m == 2 && auto_return_idle)
               || (m == 3 && auto_return_idle && cnt == 3);
            if (m == 3 && auto_return_idle) cnt = (cnt + 1) % 4;
         end
         @(negedge mclk);
         chk(clear_channel_flag, ef);
         chk(cal_start, ec);
         {rssi_below_thresh, receiving_packet, idle_exit, auto_return_idle} = 4'h0;
         calibrate_strobe = 1'b0;
      end
      conclude();
   end
endmodule
bind rnc_config rnc_config_props u_rnc_config_props (.mclk, .resetn, .reg_addr, .reg_wdata,
   .reg_wr_en, .reg_rd_en, .reg_rdata, .rssi_below_thresh, .receiving_packet,
   .clear_channel_flag, .rx_done, .tx_done, .next_state, .next_state_valid, .calibrate_strobe,
   .idle_exit, .auto_return_idle, .cal_start, .after_receive_next_state,
   .after_transmit_next_state, .synth_autocal_select);
`default_nettype wire
